/* hw/sdio_irq_pkg.sv */
// Shared constants and types for the card interrupt and read-pause service block
package sdio_irq_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_BLKCNT = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_EVT    = 8'h0c;
    localparam logic [7:0] ADDR_MASK   = 8'h10;
    localparam logic [7:0] ADDR_CMD    = 8'h14;
    // ==========================================================
    // Field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_WIDE  = 1;
    localparam int CTRL_PAUSE = 2;
    localparam int STAT_BUSY  = 0;
    localparam int STAT_PAUSE = 1;
    localparam int STAT_LOW   = 2;
    localparam int STAT_IRQP  = 3;
    localparam int STAT_BYTE  = 16;
    localparam int EVT_LEVEL  = 0;
    localparam int EVT_CARD   = 1;
    localparam int EVT_BLOCK  = 2;
    localparam int EVT_DONE   = 3;
    localparam int EVT_REJECT = 4;
    localparam int EVT_W      = 5;
    // ==========================================================
    // Counts and reset values
    localparam logic [9:0]  BLOCK_BYTES      = 10'h200 - 10'h001;
    localparam logic [2:0]  BYTE_EDGES_1BIT  = 3'h7;
    localparam logic [2:0]  BYTE_EDGES_4BIT  = 3'h1;
    localparam logic [1:0]  IRQ_PERIOD_EDGES = 2'h1;
    localparam logic [15:0] BLKCNT_RESET     = 16'h0000;
    localparam logic [EVT_W-1:0] MASK_RESET  = 5'h00;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {X_IDLE, X_DATA, X_IRQP} xfer_t;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wbReq_t;
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wbRsp_t;
    typedef struct packed {
        logic busClk;
        logic irqDataLine;
    } cardIn_t;
    typedef struct packed {
        logic        busClkEn;
        logic [3:0]  laneEn;
        logic        cmdStart;
        logic [31:0] cmdArg;
    } cardOut_t;
endpackage

/* hw/sdio_irq_read_pause_ctrl.sv */
// Card interrupt detection and read-pause control with a Wishbone register port
// Functional notes
// - One-bit mode: interrupt line carries no data
// - One-bit mode: interrupt follows line low level
// - Four-bit mode: sample line only in period
// - Interrupt period only between 512-byte blocks
// - Pause freezes counters, bus clock keeps running
// - Commands accepted and issued during pause
// - Leaving pause resumes from frozen values
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
module sdio_irq_read_pause_ctrl (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire sdio_irq_pkg::wbReq_t wbReq,
    output      sdio_irq_pkg::wbRsp_t wbRsp,
    input  wire sdio_irq_pkg::cardIn_t  cardIn,
    output      sdio_irq_pkg::cardOut_t cardOut,
    output      logic                 irq
);
    import sdio_irq_pkg::*;

    typedef struct packed {
        logic             clk1;
        logic             clk2;
        logic             clkPrev;
        logic             irq1;
        logic             irq2;
        logic             wide;
        logic             pause;
        xfer_t            xfer;
        logic [2:0]       edgeCnt;
        logic [9:0]       byteCnt;
        logic [1:0]       periodCnt;
        logic [15:0]      blkCnt;
        logic [EVT_W-1:0] evt;
        logic [EVT_W-1:0] mask;
        logic             ack;
        logic [31:0]      rdat;
        logic             cmdStart;
        logic [31:0]      cmdArg;
    } state_t;

    state_t q;
    state_t d;
    logic   busEdge;
    logic   pauseOn;
    logic   irqLow;
    logic   busReq;
    logic   wrReq;

    // ==========================================================
    // Derived conditions
    assign busEdge = q.clk2 & ~q.clkPrev;
    assign irqLow  = ~q.irq2;
    assign pauseOn = q.pause & (q.xfer != X_IDLE);
    assign busReq  = wbReq.cyc & wbReq.stb & ~q.ack;
    assign wrReq   = busReq & wbReq.we;

    // ==========================================================
    // Next state
    always_comb begin
        logic [EVT_W-1:0] setEv;
        logic [EVT_W-1:0] clrEv;
        logic [2:0]       perByte;
        setEv   = '0;
        clrEv   = '0;
        perByte = q.wide ? BYTE_EDGES_4BIT : BYTE_EDGES_1BIT;
        d          = q;
        d.clk1     = cardIn.busClk;
        d.clk2     = q.clk1;
        d.clkPrev  = q.clk2;
        d.irq1     = cardIn.irqDataLine;
        d.irq2     = q.irq1;
        d.ack      = busReq;
        d.cmdStart = 1'b0;

        // Transfer progress, held while paused
        case (q.xfer)
            X_IDLE: begin
            end
            X_DATA: begin
                if (busEdge && !pauseOn) begin
                    if (q.edgeCnt == perByte) begin
                        d.edgeCnt = '0;
                        if (q.byteCnt == BLOCK_BYTES) begin
                            d.byteCnt        = '0;
                            d.blkCnt         = q.blkCnt - 16'h0001;
                            setEv[EVT_BLOCK] = 1'b1;
                            if (q.blkCnt == 16'h0001) begin
                                d.xfer          = X_IDLE;
                                setEv[EVT_DONE] = 1'b1;
                            end else if (q.wide) begin
                                d.xfer      = X_IRQP;
                                d.periodCnt = '0;
                            end
                        end else begin
                            d.byteCnt = q.byteCnt + 10'h001;
                        end
                    end else begin
                        d.edgeCnt = q.edgeCnt + 3'h1;
                    end
                end
            end
            X_IRQP: begin
                if (busEdge && !pauseOn) begin
                    if (irqLow) begin
                        setEv[EVT_CARD] = 1'b1;
                    end
                    if (q.periodCnt == IRQ_PERIOD_EDGES) begin
                        d.xfer = X_DATA;
                    end else begin
                        d.periodCnt = q.periodCnt + 2'h1;
                    end
                end
            end
            default: begin
                d.xfer = X_IDLE;
            end
        endcase

        // Register writes
        if (wrReq) begin
            case (wbReq.adr)
                ADDR_CTRL: begin
                    if (wbReq.sel[0]) begin
                        d.pause = wbReq.dat[CTRL_PAUSE];
                        if (q.xfer == X_IDLE) begin
                            d.wide = wbReq.dat[CTRL_WIDE];
                            if (wbReq.dat[CTRL_START] && q.blkCnt != 16'h0000) begin
                                d.xfer    = X_DATA;
                                d.edgeCnt = '0;
                                d.byteCnt = '0;
                            end
                        end
                    end
                end
                ADDR_BLKCNT: begin
                    if (q.xfer == X_IDLE) begin
                        if (wbReq.sel[0]) d.blkCnt[7:0] = wbReq.dat[7:0];
                        if (wbReq.sel[1]) d.blkCnt[15:8] = wbReq.dat[15:8];
                    end
                end
                ADDR_EVT: begin
                    if (wbReq.sel[0]) clrEv = wbReq.dat[EVT_W-1:0];
                end
                ADDR_MASK: begin
                    if (wbReq.sel[0]) d.mask = wbReq.dat[EVT_W-1:0];
                end
                ADDR_CMD: begin
                    if (q.xfer != X_IDLE && !pauseOn) begin
                        setEv[EVT_REJECT] = 1'b1;
                    end else begin
                        d.cmdStart = 1'b1;
                        if (wbReq.sel[0]) d.cmdArg[7:0] = wbReq.dat[7:0];
                        if (wbReq.sel[1]) d.cmdArg[15:8] = wbReq.dat[15:8];
                        if (wbReq.sel[2]) d.cmdArg[23:16] = wbReq.dat[23:16];
                        if (wbReq.sel[3]) d.cmdArg[31:24] = wbReq.dat[31:24];
                    end
                end
                default: begin
                end
            endcase
        end

        // Sticky events, set wins over clear; level bit follows the line in one-bit mode only
        d.evt = (q.evt & ~clrEv) | setEv;
        d.evt[EVT_LEVEL] = ~q.wide & irqLow;

        // Register reads
        d.rdat = '0;
        if (busReq && !wbReq.we) begin
            case (wbReq.adr)
                ADDR_CTRL: begin
                    d.rdat[CTRL_WIDE]  = q.wide;
                    d.rdat[CTRL_PAUSE] = q.pause;
                end
                ADDR_BLKCNT: d.rdat[15:0] = q.blkCnt;
                ADDR_STATUS: begin
                    d.rdat[STAT_BUSY]  = q.xfer != X_IDLE;
                    d.rdat[STAT_PAUSE] = pauseOn;
                    d.rdat[STAT_LOW]   = irqLow;
                    d.rdat[STAT_IRQP]  = q.xfer == X_IRQP;
                    d.rdat[STAT_BYTE +: 10] = q.byteCnt;
                end
                ADDR_EVT:  d.rdat[EVT_W-1:0] = q.evt;
                ADDR_MASK: d.rdat[EVT_W-1:0] = q.mask;
                ADDR_CMD:  d.rdat = q.cmdArg;
                default:   d.rdat = '0;
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q           <= '0;
            q.clk1      <= 1'b0;
            q.irq1      <= 1'b1;
            q.irq2      <= 1'b1;
            q.xfer      <= X_IDLE;
            q.blkCnt    <= BLKCNT_RESET;
            q.mask      <= MASK_RESET;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign wbRsp.ack        = q.ack;
    assign wbRsp.dat        = q.rdat;
    assign cardOut.busClkEn = 1'b1;
    assign cardOut.laneEn   = q.wide ? 4'hf : 4'h1;
    assign cardOut.cmdStart = q.cmdStart;
    assign cardOut.cmdArg   = q.cmdArg;
    assign irq              = |(q.evt & q.mask);

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_level_follow: assert property ((!q.wide && !q.irq2) |=> (q.evt[EVT_LEVEL] || q.wide))
        else $error("level interrupt not raised while line low");
    chk_level_release: assert property (q.irq2 |=> !q.evt[EVT_LEVEL])
        else $error("level interrupt held after line high");
    chk_lane_onebit: assert property (!q.wide |-> cardOut.laneEn == 4'h1)
        else $error("interrupt line used for data in one-bit mode");
    chk_pause_freeze: assert property (pauseOn |=> $stable(q.byteCnt) && $stable(q.edgeCnt)
        && $stable(q.blkCnt))
        else $error("counters moved during pause");
    chk_pause_clock: assert property (pauseOn |-> cardOut.busClkEn)
        else $error("bus clock stopped during pause");
    chk_cmd_pause: assert property ((wrReq && wbReq.adr == ADDR_CMD && pauseOn)
        |=> cardOut.cmdStart && !q.evt[EVT_REJECT] || $past(q.evt[EVT_REJECT]))
        else $error("command refused during pause");
    chk_resume_keep: assert property ($fell(pauseOn) && q.xfer != X_IDLE
        |-> $stable(q.byteCnt) && $stable(q.blkCnt))
        else $error("counters lost on leaving pause");
    chk_card_sample: assert property ((q.xfer == X_IRQP && busEdge && !pauseOn && !q.irq2)
        |=> q.evt[EVT_CARD])
        else $error("sampled card interrupt not latched");
    chk_period_edge: assert property ($rose(q.xfer == X_IRQP) |-> q.byteCnt == 10'h000 && q.wide)
        else $error("interrupt period off block boundary");
    chk_period_wide: assert property (!q.wide |-> q.xfer != X_IRQP)
        else $error("interrupt period in one-bit mode");
    chk_pause_flag: assert property ((wrReq && wbReq.adr == ADDR_CTRL && wbReq.sel[0]
        && wbReq.dat[CTRL_PAUSE] && q.xfer == X_DATA && !busEdge) |=> pauseOn)
        else $error("pause flag not set");
endmodule

/* bench/sdio_card_model.sv */
// Behavioural card model on the far side of the card link
`timescale 1ns/100ps
module sdio_card_model (
    input  wire logic                  clkRun,
    input  wire logic                  intPending,
    output      sdio_irq_pkg::cardIn_t cardIn
);
    import sdio_irq_pkg::*;
    // ==========================================================
    // Bus clock, held low while clkRun is low
    logic busClk = 1'b0;
    initial begin
        #37;
        forever begin
            #100;
            busClk = clkRun ? ~busClk : 1'b0;
        end
    end
    // ==========================================================
    // Interrupt line, pulled up, held low while pending
    assign cardIn.busClk      = busClk;
    assign cardIn.irqDataLine = intPending ? 1'b0 : 1'b1;
endmodule

/* bench/sdio_irq_read_pause_ctrl_bench.sv */
// Self-checking bench for the card interrupt and read-pause block
`timescale 1ns/100ps
module sdio_irq_read_pause_ctrl_bench;
    import sdio_irq_pkg::*;
    // ==========================================================
    // Clock, reset and partner
    logic        clk = 1'b0, nrst = 1'b0, clkRun = 1'b0, intPending = 1'b0, irq;
    wbReq_t      req = '0;
    wbRsp_t      rsp;
    cardIn_t     cardIn;
    cardOut_t    cardOut;
    int          badCount = 0, nCompared = 0, nStarts = 0;
    logic [31:0] rd, arg, cnt;
    initial begin
        forever #12.5 clk = ~clk;
    end
    sdio_card_model i_card (.clkRun(clkRun), .intPending(intPending), .cardIn(cardIn));
    sdio_irq_read_pause_ctrl i_dut (.clk(clk), .nrst(nrst), .wbReq(req), .wbRsp(rsp),
        .cardIn(cardIn), .cardOut(cardOut), .irq(irq));
    always @(negedge clk) if (cardOut.cmdStart === 1'b1) nStarts++;
    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        nCompared++;
        if (s !== e) begin
            badCount++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b1, w, a, 4'hf, d};
        do begin
            @(posedge clk);
            n++;
        end while (rsp.ack !== 1'b1);
        rd = rsp.dat;
        req <= '0;
        chk("ack latency", 32'h2, n);
    endtask
    task automatic await(input int pos, input logic v);
        int n;
        n = 0;
        do begin
            wb(1'b0, ADDR_STATUS, '0);
            n++;
        end while (rd[pos] !== v && n < 20000);
        chk("status wait", {31'h0, v}, {31'h0, rd[pos]});
    endtask
    task automatic tally_and_finish;
        if (badCount == 0 && nCompared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #2250000;
        badCount++;
        tally_and_finish;
    end
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(38207));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        chk("laneEn", 32'h1, {28'h0, cardOut.laneEn});
        wb(1'b0, ADDR_MASK, '0);
        chk("mask reset", {27'h0, MASK_RESET}, rd);
        wb(1'b0, 8'h18, '0);
        chk("unmapped", 32'h0, rd);
        wb(1'b1, ADDR_MASK, 32'h1 << EVT_LEVEL);
        intPending <= 1'b1;
        repeat (8) @(negedge clk);
        chk("irq line low", 32'h1, {31'h0, irq});
        @(posedge clk);
        intPending <= 1'b0;
        repeat (8) @(negedge clk);
        chk("irq line high", 32'h0, {31'h0, irq});
        wb(1'b1, ADDR_MASK, '0);
        wb(1'b1, ADDR_BLKCNT, 32'h2);
        clkRun <= 1'b1;
        intPending <= 1'b1;
        wb(1'b1, ADDR_CTRL, 32'h3);
        repeat (200 + $urandom_range(2000)) @(negedge clk);
        chk("laneEn wide", 32'hf, {28'h0, cardOut.laneEn});
        wb(1'b0, ADDR_EVT, '0);
        chk("card outside period", 32'h0, rd & (32'h1 << EVT_CARD));
        arg = $urandom;
        wb(1'b1, ADDR_CMD, arg);
        wb(1'b0, ADDR_EVT, '0);
        chk("reject", 32'h1 << EVT_REJECT, rd & (32'h1 << EVT_REJECT));
        chk("no start", 32'h0, nStarts);
        chk("arg kept", 32'h0, cardOut.cmdArg);
        wb(1'b1, ADDR_EVT, 32'h1f);
        wb(1'b1, ADDR_CTRL, 32'h6);
        wb(1'b0, ADDR_STATUS, '0);
        cnt = rd;
        chk("pause flag", 32'h1, {31'h0, rd[STAT_PAUSE]});
        repeat (100) @(negedge clk);
        wb(1'b1, ADDR_CMD, arg);
        chk("cmd start", 32'h1, nStarts);
        chk("cmd arg", arg, cardOut.cmdArg);
        chk("clock on", 32'h1, {31'h0, cardOut.busClkEn});
        wb(1'b0, ADDR_STATUS, '0);
        chk("frozen status", cnt, rd);
        wb(1'b1, ADDR_CTRL, 32'h2);
        repeat (40) @(negedge clk);
        wb(1'b0, ADDR_STATUS, '0);
        chk("resumed", 32'h1, {31'h0, rd[25:16] > cnt[25:16]});
        chk("pause off", 32'h0, {31'h0, rd[STAT_PAUSE]});
        await(STAT_IRQP, 1'b1);
        wb(1'b0, ADDR_EVT, '0);
        chk("period at boundary", 32'h1 << EVT_BLOCK, rd & 32'hc);
        await(STAT_BUSY, 1'b0);
        clkRun <= 1'b0;
        intPending <= 1'b0;
        wb(1'b0, ADDR_EVT, '0);
        chk("events", 32'he, rd & 32'he);
        wb(1'b1, ADDR_MASK, 32'h1 << EVT_CARD);
        @(negedge clk);
        chk("irq card", 32'h1, {31'h0, irq});
        wb(1'b1, ADDR_EVT, 32'h1 << EVT_CARD);
        wb(1'b0, ADDR_EVT, '0);
        chk("card cleared", 32'h0, rd & (32'h1 << EVT_CARD));
        chk("irq cleared", 32'h0, {31'h0, irq});
        wb(1'b1, ADDR_EVT, 32'h1f);
        wb(1'b1, ADDR_BLKCNT, 32'h1);
        clkRun <= 1'b1;
        intPending <= 1'b1;
        wb(1'b1, ADDR_CTRL, 32'h1);
        chk("laneEn narrow", 32'h1, {28'h0, cardOut.laneEn});
        await(STAT_BUSY, 1'b0);
        wb(1'b0, ADDR_EVT, '0);
        chk("one-bit run", 32'hd, rd & 32'hf);
        clkRun <= 1'b0;
        intPending <= 1'b0;
        tally_and_finish;
    end
endmodule
